// ### fault_pkg.sv
package fault_pkg;
   // Register byte offsets (APB, one aligned word each)
   localparam logic [7:0] OFS_CHECK_EN = 8'h00;
   localparam logic [7:0] OFS_ACTION = 8'h04;
   localparam logic [7:0] OFS_SWITCH_CFG = 8'h08;
   localparam logic [7:0] OFS_HOST_CMD = 8'h0C;
   localparam logic [7:0] OFS_DELAY = 8'h10;
   localparam logic [7:0] OFS_BODY_THR = 8'h14;
   localparam logic [7:0] OFS_ALERT_STAT = 8'h18;
   localparam logic [7:0] OFS_FAULT_STAT = 8'h1C;
   localparam logic [7:0] OFS_SWITCH_STAT = 8'h20;
   // Field positions: action register
   localparam int ACT_HOLD_OFF = 0;
   localparam int ACT_FUSE = 1;
   localparam int ACT_STORE = 2;
   localparam int ACT_REG_OFF = 3;
   localparam int ACT_DEEP = 4;
   // Field positions: switch configuration
   localparam int CFG_PARALLEL = 0;
   localparam int CFG_OVERDRIVE_HI = 1;
   localparam int CFG_SRC_FOLLOW = 2;
   localparam int CFG_MODE_LO = 3;
   // Field positions: host command
   localparam int CMD_CHG_OFF = 0;
   localparam int CMD_DSG_OFF = 1;
   localparam int CMD_REG_ON = 2;
   // Control modes
   localparam logic [1:0] MODE_AUTO = 2'h0;
   localparam logic [1:0] MODE_PARTIAL = 2'h1;
   localparam logic [1:0] MODE_MANUAL = 2'h2;
   // Reset values
   localparam logic [7:0] RST_CHECK_EN = 8'h00;
   localparam logic [4:0] RST_ACTION = 5'h01;
   localparam logic [4:0] RST_SWITCH_CFG = 5'h00;
   localparam logic [3:0] RST_DELAY = 4'h2;
   localparam logic [15:0] RST_BODY_THR = 16'h0064;
   // Geometry and timing
   localparam int NUM_CHECKS = 8;
   localparam int CLK_HZ = 200_000_000;
   localparam int EVAL_PERIOD_S = 1;
   localparam int EVAL_CYCLES = CLK_HZ * EVAL_PERIOD_S;
endpackage

// ### fault_check.sv
`timescale 1ns/10ps
module fault_check (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic enable,
   input wire logic strobe,
   input wire logic over_thr,
   input wire logic [3:0] delay,
   output logic alert,
   output logic fault
);
   logic [3:0] cnt_r;
   logic alert_r;
   logic fault_r;
   wire logic hit = enable & strobe & over_thr;
   wire logic expire = hit & (cnt_r >= delay);
   assign alert = alert_r;
   assign fault = fault_r;
   // Alert follows the condition only at the periodic check
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_r <= 4'h0;
         alert_r <= 1'b0;
         fault_r <= 1'b0;
      end
      else if (!enable)
      begin
         cnt_r <= 4'h0;
         alert_r <= 1'b0;
      end
      else if (strobe)
      begin
         alert_r <= over_thr;
         cnt_r <= over_thr ? ((cnt_r == 4'hF) ? cnt_r : cnt_r + 4'h1) : 4'h0;
         if (expire)
         begin
            fault_r <= 1'b1;
         end
      end
   end
endmodule

// ### pack_fault_and_switch_control.sv
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
// Behaviour
// - Each lasting-fault check is enabled separately and has its own delay.
// - Fault action: flag only, hold switches off, or drive the fuse.
// - Fuse pin drives out and is watched for a blow by another protector.
// - Fault status held in flops; optionally stored in one-time memory.
// - One-time memory write waits for adequate supply and temperature.
// - Deepest low-power entry waits for the memory write when storing is enabled, not for a fuse blow.
// - Fault may turn the auxiliary regulator off; command turns it on.
// - Alert sets when an enabled check first sees its threshold.
// - Fault declared only after the programmed delay with condition present.
// - Checks are evaluated only at one-second intervals.
// - Alert clears when a periodic check sees condition below threshold, or at once when its check is disabled.
// - Gate overdrive level chosen by configuration, 5.5V or 11V.
// - Source-follower drive in sleep; discharge current moves to pump drive.
// - Switch logic adapts to series or parallel arrangement.
// - Autonomous mode turns switches off and back on without the host.
// - Partial mode: host command holds switches off until released.
// - Blocking pins keep their switch off unless the body-diode guard turns it on; release only if nothing else blocks.
// - Manual mode alerts host; host forces switches off by pin or command.
// - Series: charge switch on during large discharge current to guard diode.
// - Series: discharge switch on during large charge current to guard diode.
// - Parallel arrangement disables body-diode protection.
module pack_fault_and_switch_control #(
   parameter int EVAL_CYCLES = fault_pkg::EVAL_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] check_over_thr,
   input wire logic primary_fault_chg,
   input wire logic primary_fault_dsg,
   input wire logic sleep_mode,
   input wire logic signed [15:0] current,
   input wire logic charge_switch_block_pin,
   input wire logic discharge_switch_block_pin,
   input wire logic precharge_switch,
   input wire logic predischarge_switch,
   input wire logic otp_conditions_ok,
   input wire logic otp_done,
   input wire logic fuse_in,
   output logic fuse_out,
   output logic fuse_oe_n,
   output logic otp_write_req,
   output logic charge_switch,
   output logic discharge_switch,
   output logic dsg_source_follow,
   output logic pump_overdrive_hi,
   output logic auxiliary_regulator,
   output logic deepest_low_power_state,
   output logic alert_pin,
   output logic fuse_blow_seen
);
   localparam int N = fault_pkg::NUM_CHECKS;
   localparam int CW = $clog2(EVAL_CYCLES + 1);

   logic [7:0] check_en_r;
   logic [4:0] action_r;
   logic [4:0] cfg_r;
   logic [1:0] host_off_r;
   logic [31:0] delay_r;
   logic [15:0] body_thr_r;
   logic [CW-1:0] tick_r;
   logic strobe_r;
   logic [N-1:0] alert_v;
   logic [N-1:0] fault_v;
   logic [1:0] cblk_s;
   logic [1:0] dblk_s;
   logic [1:0] fin_s;
   logic fuse_r;
   logic blow_seen_r;
   logic otp_req_r;
   logic otp_ok_r;
   logic reg_on_r;
   logic deep_r;
   logic lasting_fault_r;
   logic [31:0] rdata_nxt;

   // Periodic evaluation strobe, one pulse per second
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tick_r <= '0;
         strobe_r <= 1'b0;
      end
      else
      begin
         strobe_r <= (tick_r == CW'(EVAL_CYCLES - 1));
         tick_r <= (tick_r == CW'(EVAL_CYCLES - 1)) ? '0 : tick_r + CW'(1);
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < N; gi++)
      begin : g_chk
         fault_check u_chk (
            .pclk(pclk),
            .presetn(presetn),
            .enable(check_en_r[gi]),
            .strobe(strobe_r),
            .over_thr(check_over_thr[gi]),
            .delay(delay_r[gi*4 +: 4]),
            .alert(alert_v[gi]),
            .fault(fault_v[gi])
         );
      end
   endgenerate

   wire logic any_fault = |fault_v;
   wire logic any_alert = |alert_v;

   // Pin synchronisers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cblk_s <= 2'b00;
         dblk_s <= 2'b00;
         fin_s <= 2'b00;
      end
      else
      begin
         cblk_s <= {cblk_s[0], charge_switch_block_pin};
         dblk_s <= {dblk_s[0], discharge_switch_block_pin};
         fin_s <= {fin_s[0], fuse_in};
      end
   end
   wire logic cblk = cblk_s[1];
   wire logic dblk = dblk_s[1];

   // APB decode
   wire logic wr = psel & penable & pwrite;
   wire logic rd_ok = (paddr[1:0] == 2'b00) && (paddr <= fault_pkg::OFS_SWITCH_STAT);
   wire logic w_en = wr & (paddr == fault_pkg::OFS_CHECK_EN);
   wire logic w_act = wr & (paddr == fault_pkg::OFS_ACTION);
   wire logic w_cfg = wr & (paddr == fault_pkg::OFS_SWITCH_CFG);
   wire logic w_cmd = wr & (paddr == fault_pkg::OFS_HOST_CMD);
   wire logic w_dly = wr & (paddr == fault_pkg::OFS_DELAY);
   wire logic w_thr = wr & (paddr == fault_pkg::OFS_BODY_THR);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~rd_ok;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         check_en_r <= fault_pkg::RST_CHECK_EN;
         action_r <= fault_pkg::RST_ACTION;
         cfg_r <= fault_pkg::RST_SWITCH_CFG;
         host_off_r <= 2'b00;
         delay_r <= {8{fault_pkg::RST_DELAY}};
         body_thr_r <= fault_pkg::RST_BODY_THR;
      end
      else
      begin
         if (w_en)
            check_en_r <= pwdata[7:0];
         if (w_act)
            action_r <= pwdata[4:0];
         if (w_cfg)
            cfg_r <= pwdata[4:0];
         if (w_cmd)
            host_off_r <= pwdata[1:0];
         if (w_dly)
            delay_r <= pwdata;
         if (w_thr)
            body_thr_r <= pwdata[15:0];
      end
   end

   wire logic [1:0] mode = cfg_r[fault_pkg::CFG_MODE_LO +: 2];
   wire logic parallel = cfg_r[fault_pkg::CFG_PARALLEL];
   wire logic fault_rise = any_fault & ~lasting_fault_r;

   // Lasting fault actions
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lasting_fault_r <= 1'b0;
         fuse_r <= 1'b0;
         blow_seen_r <= 1'b0;
         otp_req_r <= 1'b0;
         otp_ok_r <= 1'b0;
         reg_on_r <= 1'b1;
         deep_r <= 1'b0;
      end
      else
      begin
         lasting_fault_r <= lasting_fault_r | any_fault;
         if (any_fault && action_r[fault_pkg::ACT_FUSE])
            fuse_r <= 1'b1;
         if (fin_s[1] && !fuse_r)
            blow_seen_r <= 1'b1;
         if (fault_rise && action_r[fault_pkg::ACT_STORE])
            otp_req_r <= 1'b1;
         else if (otp_req_r && otp_done)
            otp_req_r <= 1'b0;
         if (otp_req_r && otp_done)
            otp_ok_r <= 1'b1;
         if (fault_rise && action_r[fault_pkg::ACT_REG_OFF])
            reg_on_r <= 1'b0;
         else if (w_cmd && pwdata[fault_pkg::CMD_REG_ON])
            reg_on_r <= 1'b1;
         if (lasting_fault_r && action_r[fault_pkg::ACT_DEEP] && !otp_req_r
             && (!action_r[fault_pkg::ACT_STORE] || otp_ok_r))
            deep_r <= 1'b1;
      end
   end

   assign fuse_out = fuse_r;
   assign fuse_oe_n = ~fuse_r;
   assign fuse_blow_seen = blow_seen_r;
   assign otp_write_req = otp_req_r & otp_conditions_ok;
   assign auxiliary_regulator = reg_on_r;
   assign deepest_low_power_state = deep_r;
   assign pump_overdrive_hi = cfg_r[fault_pkg::CFG_OVERDRIVE_HI];
   assign alert_pin = any_alert | any_fault | primary_fault_chg | primary_fault_dsg;

   // Switch arbitration
   wire logic pf_hold = lasting_fault_r & (action_r[fault_pkg::ACT_HOLD_OFF] | fuse_r);
   wire logic auto_chg = (mode != fault_pkg::MODE_MANUAL) & primary_fault_chg;
   wire logic auto_dsg = (mode != fault_pkg::MODE_MANUAL) & primary_fault_dsg;
   wire logic chg_block = pf_hold | auto_chg | cblk | host_off_r[fault_pkg::CMD_CHG_OFF];
   wire logic dsg_block = pf_hold | auto_dsg | dblk | host_off_r[fault_pkg::CMD_DSG_OFF];
   // Threshold widened by one bit so a magnitude above half scale never turns negative
   wire logic big_dsg = current < -$signed({1'b0, body_thr_r});
   wire logic big_chg = current > $signed({1'b0, body_thr_r});
   wire logic chg_guard = ~parallel & ~pf_hold & (discharge_switch | predischarge_switch)
                          & big_dsg;
   wire logic dsg_guard = ~parallel & ~pf_hold & (charge_switch | precharge_switch)
                          & big_chg;
   logic chg_r;
   logic dsg_r;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         chg_r <= 1'b0;
         dsg_r <= 1'b0;
      end
      else
      begin
         chg_r <= ~chg_block | chg_guard;
         dsg_r <= ~dsg_block | dsg_guard;
      end
   end
   assign charge_switch = chg_r;
   assign discharge_switch = dsg_r;
   assign dsg_source_follow = cfg_r[fault_pkg::CFG_SRC_FOLLOW] & sleep_mode
                              & ~big_dsg & ~deep_r;

   // Read mux
   always_comb
   begin
      rdata_nxt = 32'h0000_0000;
      case (paddr)
         fault_pkg::OFS_CHECK_EN: rdata_nxt[7:0] = check_en_r;
         fault_pkg::OFS_ACTION: rdata_nxt[4:0] = action_r;
         fault_pkg::OFS_SWITCH_CFG: rdata_nxt[4:0] = cfg_r;
         fault_pkg::OFS_HOST_CMD: rdata_nxt[2:0] = {reg_on_r, host_off_r};
         fault_pkg::OFS_DELAY: rdata_nxt = delay_r;
         fault_pkg::OFS_BODY_THR: rdata_nxt[15:0] = body_thr_r;
         fault_pkg::OFS_ALERT_STAT: rdata_nxt[7:0] = alert_v;
         fault_pkg::OFS_FAULT_STAT: rdata_nxt[9:0] = {lasting_fault_r, blow_seen_r, fault_v};
         fault_pkg::OFS_SWITCH_STAT: rdata_nxt[4:0] = {deep_r, otp_ok_r, fuse_r, dsg_r, chg_r};
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= rdata_nxt;
   end

   // Assertions
   sequence store_fault_s;
      fault_rise && action_r[fault_pkg::ACT_STORE];
   endsequence
   sequence otp_finish_s;
      otp_req_r && otp_done;
   endsequence
   sequence hold_fault_s;
      lasting_fault_r && action_r[fault_pkg::ACT_HOLD_OFF];
   endsequence
   strobe_spacing_a: assert property (@(posedge pclk) disable iff (!presetn)
      strobe_r |=> !strobe_r) else $error("strobe repeated");
   fuse_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      any_fault && action_r[1] |=> fuse_out) else $error("fuse not driven");
   hold_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      pf_hold && !chg_guard |=> !charge_switch) else $error("charge on under hold");
   chg_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
      cblk && !chg_guard |=> !charge_switch) else $error("charge pin ignored");
   dsg_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
      dblk && !dsg_guard |=> !discharge_switch) else $error("discharge pin ignored");
   parallel_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
      parallel |-> !chg_guard && !dsg_guard) else $error("guard in parallel");
   deep_order_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(deep_r) |-> !otp_req_r) else $error("deep before memory write");
   otp_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      otp_write_req |-> otp_conditions_ok) else $error("write in bad conditions");
   reg_cmd_a: assert property (@(posedge pclk) disable iff (!presetn)
      w_cmd && pwdata[2] && !fault_rise |=> auxiliary_regulator)
      else $error("regulator not reenabled");
   alert_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !strobe_r && check_en_r == $past(check_en_r) |=> alert_v == $past(alert_v))
      else $error("alert changed between checks");
   alert_strobe_a: assert property (@(posedge pclk) disable iff (!presetn)
      strobe_r |=> alert_v == ($past(check_en_r) & $past(check_over_thr)))
      else $error("alert not taken at check");
   fault_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
      lasting_fault_r |=> lasting_fault_r)
      else $error("lasting fault lost");
   otp_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
      store_fault_s |=> otp_req_r)
      else $error("memory write not requested");
   otp_finish_a: assert property (@(posedge pclk) disable iff (!presetn)
      otp_finish_s |=> !otp_req_r && otp_ok_r)
      else $error("memory write not closed");
   reg_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      fault_rise && action_r[fault_pkg::ACT_REG_OFF] |=> !auxiliary_regulator)
      else $error("regulator left on");
   hold_both_a: assert property (@(posedge pclk) disable iff (!presetn)
      hold_fault_s |=> !charge_switch && !discharge_switch)
      else $error("switch on under fault hold");
   deep_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(deep_r) |-> lasting_fault_r)
      else $error("deep sleep without fault");
   parallel_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      parallel && chg_block |=> !charge_switch)
      else $error("charge on in parallel");
   manual_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      mode == fault_pkg::MODE_MANUAL && !pf_hold && !cblk
      && !host_off_r[fault_pkg::CMD_CHG_OFF] |=> charge_switch)
      else $error("manual charge blocked");
   follow_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
      big_dsg |-> !dsg_source_follow)
      else $error("follower during discharge");
   blow_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
      fuse_blow_seen |=> fuse_blow_seen)
      else $error("blow flag lost");
endmodule

// ### host_model.sv
`timescale 1ns/10ps
module host_model #(
   parameter int OTP_LAT = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic want_chg_off,
   input wire logic want_dsg_off,
   input wire logic otp_write_req,
   output logic charge_switch_block_pin,
   output logic discharge_switch_block_pin,
   output logic otp_done
);
   logic [3:0] wait_r;
   // The memory writer answers late on purpose so deep sleep must really wait
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         charge_switch_block_pin <= 1'b0;
         discharge_switch_block_pin <= 1'b0;
         wait_r <= 4'h0;
         otp_done <= 1'b0;
      end
      else
      begin
         charge_switch_block_pin <= want_chg_off;
         discharge_switch_block_pin <= want_dsg_off;
         wait_r <= otp_write_req ? wait_r + 4'h1 : 4'h0;
         otp_done <= otp_write_req && (wait_r >= OTP_LAT[3:0]);
      end
   end
endmodule

// ### pack_fault_and_switch_control_bench.sv
`timescale 1ns/10ps
module pack_fault_and_switch_control_bench;
   localparam int EVAL = 16;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, check_over_thr = 8'h00, pat;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd_v;
   logic primary_fault_chg = 1'b0, primary_fault_dsg = 1'b0, sleep_mode = 1'b0;
   logic precharge_switch = 1'b0, predischarge_switch = 1'b0, otp_conditions_ok = 1'b0;
   logic fuse_in = 1'b0, want_chg_off = 1'b0, want_dsg_off = 1'b0;
   logic signed [15:0] current = 16'h0000;
   logic pready, pslverr, last_err, otp_done, fuse_out, fuse_oe_n, otp_write_req;
   logic charge_switch, discharge_switch, dsg_source_follow, pump_overdrive_hi;
   logic auxiliary_regulator, deepest_low_power_state, alert_pin, fuse_blow_seen;
   logic charge_switch_block_pin, discharge_switch_block_pin;
   logic [4:0] act;
   int n_fail = 0;
   int checks_done = 0;
   int seed = 69;
   always #2.5 pclk = ~pclk;
   pack_fault_and_switch_control #(.EVAL_CYCLES(EVAL)) i_pack_fault_and_switch_control (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .check_over_thr(check_over_thr), .primary_fault_chg(primary_fault_chg),
      .primary_fault_dsg(primary_fault_dsg), .sleep_mode(sleep_mode), .current(current),
      .charge_switch_block_pin(charge_switch_block_pin),
      .discharge_switch_block_pin(discharge_switch_block_pin),
      .precharge_switch(precharge_switch), .predischarge_switch(predischarge_switch),
      .otp_conditions_ok(otp_conditions_ok), .otp_done(otp_done), .fuse_in(fuse_in),
      .fuse_out(fuse_out), .fuse_oe_n(fuse_oe_n), .otp_write_req(otp_write_req),
      .charge_switch(charge_switch), .discharge_switch(discharge_switch),
      .dsg_source_follow(dsg_source_follow), .pump_overdrive_hi(pump_overdrive_hi),
      .auxiliary_regulator(auxiliary_regulator),
      .deepest_low_power_state(deepest_low_power_state), .alert_pin(alert_pin),
      .fuse_blow_seen(fuse_blow_seen)
   );
   host_model i_host_model (
      .pclk(pclk), .presetn(presetn), .want_chg_off(want_chg_off),
      .want_dsg_off(want_dsg_off), .otp_write_req(otp_write_req),
      .charge_switch_block_pin(charge_switch_block_pin),
      .discharge_switch_block_pin(discharge_switch_block_pin), .otp_done(otp_done)
   );
   function automatic logic [4:0] fault_exp(input logic [4:0] a);
      fault_exp = {!a[1], a[1], !a[3], !(a[0] | a[1]), !(a[0] | a[1])};
   endfunction
   task stop_test;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd_v = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, e, rd_v);
   endtask
   task settle(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask
   task do_reset;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
   endtask
   // Leaves the caller on the edge one cycle after the strobe edge that raised the alert
   task wait_alert;
      int k;
      k = 0;
      while (alert_pin !== 1'b1 && k < 40)
      begin
         @(posedge pclk);
         k++;
      end
      chk("alert_wait", 32'h0000_0001, alert_pin);
   endtask
   initial
   begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      stop_test;
   end
   initial
   begin
      do_reset;
      rd(fault_pkg::OFS_CHECK_EN, 32'h0000_0000, "check_en");
      rd(fault_pkg::OFS_ACTION, 32'h0000_0001, "action");
      rd(fault_pkg::OFS_DELAY, 32'h2222_2222, "delays");
      rd(fault_pkg::OFS_BODY_THR, 32'h0000_0064, "body_thr");
      rd(8'h24, 32'h0000_0000, "unmapped");
      chk("unmapped_err", 32'h0000_0001, last_err);
      chk("ready", 32'h0000_0001, pready);
      apb(1'b1, fault_pkg::OFS_ALERT_STAT, 32'hFFFF_FFFF);
      rd(fault_pkg::OFS_ALERT_STAT, 32'h0000_0000, "alert_ro");
      @(posedge pclk);
      fuse_in <= 1'b1;
      settle(4);
      chk("blow_seen", 32'h0000_0001, fuse_blow_seen);
      @(posedge pclk);
      fuse_in <= 1'b0; // Released, else every later reset would see a fresh blow
      settle(4);
      chk("blow_sticky", 32'h0000_0001, fuse_blow_seen);
      $display("test registers done");
      for (int i = 1; i < 5; i++)
      begin
         @(posedge pclk);
         want_chg_off <= i[0];
         want_dsg_off <= i[1];
         settle(6);
         chk("pin_chg", !i[0], charge_switch);
         chk("pin_dsg", !i[1], discharge_switch);
      end
      @(posedge pclk);
      primary_fault_chg <= 1'b1;
      settle(3);
      chk("auto_off", 32'h0000_0000, charge_switch);
      @(posedge pclk);
      primary_fault_chg <= 1'b0;
      settle(3);
      chk("auto_on", 32'h0000_0001, charge_switch);
      apb(1'b1, fault_pkg::OFS_SWITCH_CFG, 32'h0000_0008);
      apb(1'b1, fault_pkg::OFS_HOST_CMD, 32'h0000_0003);
      settle(2);
      chk("cmd_off", 32'h0000_0000, {charge_switch, discharge_switch});
      apb(1'b1, fault_pkg::OFS_HOST_CMD, 32'h0000_0000);
      settle(2);
      chk("cmd_on", 32'h0000_0003, {charge_switch, discharge_switch});
      apb(1'b1, fault_pkg::OFS_SWITCH_CFG, 32'h0000_0010);
      primary_fault_chg <= 1'b1;
      settle(3);
      chk("manual", 32'h0000_0001, charge_switch);
      apb(1'b1, fault_pkg::OFS_SWITCH_CFG, 32'h0000_0000);
      primary_fault_chg <= 1'b0;
      want_chg_off <= 1'b1;
      current <= -16'sd200;
      settle(6);
      chk("diode_chg", 32'h0000_0001, charge_switch);
      @(posedge pclk);
      current <= 16'($random(seed) % 90);
      settle(3);
      chk("diode_low", 32'h0000_0000, charge_switch);
      apb(1'b1, fault_pkg::OFS_SWITCH_CFG, 32'h0000_0001);
      current <= -16'sd200;
      settle(3);
      chk("parallel", 32'h0000_0000, charge_switch);
      apb(1'b1, fault_pkg::OFS_SWITCH_CFG, 32'h0000_0000);
      want_chg_off <= 1'b0;
      want_dsg_off <= 1'b1;
      current <= 16'sd200;
      settle(6);
      chk("diode_dsg", 32'h0000_0001, discharge_switch);
      apb(1'b1, fault_pkg::OFS_SWITCH_CFG, 32'h0000_0006);
      want_dsg_off <= 1'b0;
      sleep_mode <= 1'b1;
      current <= 16'h0000;
      settle(3);
      chk("overdrive", 32'h0000_0001, pump_overdrive_hi);
      chk("follower", 32'h0000_0001, dsg_source_follow);
      @(posedge pclk);
      current <= -16'sd200;
      settle(3);
      chk("follow_off", 32'h0000_0000, dsg_source_follow);
      apb(1'b1, fault_pkg::OFS_SWITCH_CFG, 32'h0000_0000);
      sleep_mode <= 1'b0;
      current <= 16'h0000;
      settle(2);
      chk("underdrive", 32'h0000_0000, pump_overdrive_hi);
      $display("test switch control done");
      pat = 8'($random(seed)) | 8'h01;
      apb(1'b1, fault_pkg::OFS_DELAY, 32'hFFFF_FFFF);
      apb(1'b1, fault_pkg::OFS_CHECK_EN, 32'h0000_00FF);
      check_over_thr <= pat;
      wait_alert;
      check_over_thr <= 8'h00;
      repeat (3) @(posedge pclk);
      check_over_thr <= pat;
      rd(fault_pkg::OFS_ALERT_STAT, {24'h00_0000, pat}, "alert_dip");
      check_over_thr <= 8'h00;
      settle(40);
      chk("alert_clear", 32'h0000_0000, alert_pin);
      $display("test alerts done");
      for (int j = 0; j < 3; j++)
      begin
         act = (j == 0) ? 5'h00 : (j == 1) ? 5'h01 : 5'h1F;
         do_reset;
         apb(1'b1, fault_pkg::OFS_ACTION, {27'h000_0000, act});
         apb(1'b1, fault_pkg::OFS_DELAY, 32'h0000_0003);
         apb(1'b1, fault_pkg::OFS_CHECK_EN, 32'h0000_0001);
         check_over_thr <= 8'h01;
         wait_alert;
         settle(18);
         rd(fault_pkg::OFS_FAULT_STAT, 32'h0000_0000, "early_fault");
         settle(64);
         rd(fault_pkg::OFS_FAULT_STAT, 32'h0000_0201, "fault_stat");
         settle(2);
         chk("fault_outs", fault_exp(act), {fuse_oe_n, fuse_out, auxiliary_regulator,
            charge_switch, discharge_switch});
         if (act[2])
         begin
            chk("otp_defer", 32'h0000_0000, otp_write_req);
            chk("deep_wait", 32'h0000_0000, deepest_low_power_state);
            @(posedge pclk);
            otp_conditions_ok <= 1'b1;
            settle(20);
            chk("deep", 32'h0000_0001, deepest_low_power_state);
            apb(1'b1, fault_pkg::OFS_HOST_CMD, 32'h0000_0004);
            settle(2);
            chk("reg_on", 32'h0000_0001, auxiliary_regulator);
         end
         @(posedge pclk);
         check_over_thr <= 8'h00;
         $display("test fault action %h done", act);
      end
      stop_test;
   end
endmodule
